//--- common/p5m_map.svh
// Constants of the port-five media-independent link
`ifndef P5M_MAP_SVH
`define P5M_MAP_SVH
// Data widths per interface clock
`define P5M_NIB_W 4
`define P5M_DIB_W 2
// Idle gap after a frame, in bit times
`define P5M_IPG_BITS 96
// Interface clock rates in kHz
`define P5M_MII_FAST_KHZ 25000
`define P5M_MII_SLOW_KHZ 2500
`define P5M_RMII_KHZ 50000
// Width of the gap counter
`define P5M_GAP_W 6
// Index of each two-way pin in the pin vectors
`define P5M_PIN_TXC 0
`define P5M_PIN_RXC 1
`define P5M_PIN_COL 2
`define P5M_PIN_CRS 3
`define P5M_PINS 4
`endif

//--- common/p5m_pkg.sv
// Types shared by both ends of the port-five link
package p5m_pkg;
	// Role taken by the device end
	typedef enum logic [1:0] {
		P5M_ROLE_PHY = 2'h1,
		P5M_ROLE_MAC = 2'h2
	} p5m_role_t;
	// States of the frame sender
	typedef enum logic [2:0] {
		P5M_EG_IDLE = 3'h1,
		P5M_EG_SEND = 3'h2,
		P5M_EG_GAP = 3'h4
	} p5m_eg_state_t;
	// One nibble of a stream with its frame marks
	typedef struct packed {
		logic first;
		logic last;
		logic err;
		logic [3:0] data;
	} p5m_word_t;
endpackage

//--- common/p5m_if.sv
// Pins of the port-five link, joining the device end and the far end
`include "p5m_map.svh"
`timescale 1ns/1ps
`default_nettype none
interface p5m_if;
	// Transmit group, driven by the far end
	logic sw_port_tx_enable;
	logic sw_port_tx_error;
	logic [3:0] sw_port_tx_data;
	// Receive group, driven by the device end
	logic sw_port_rx_valid;
	logic port_rx_error;
	logic [3:0] sw_port_rx_data;
	// Two-way pins, enables active low
	logic [`P5M_PINS-1:0] dev_pin_o;
	logic [`P5M_PINS-1:0] dev_pin_oe_n;
	logic [`P5M_PINS-1:0] far_pin_o;
	logic [`P5M_PINS-1:0] far_pin_oe_n;
	logic [`P5M_PINS-1:0] pin_lvl;
	logic sw_port_tx_clock;
	logic sw_port_rx_clock;
	logic sw_port_collision;
	logic sw_port_carrier_sense;
	// Wire level; an undriven pin reads low
	assign pin_lvl = (~dev_pin_oe_n & dev_pin_o) | (~far_pin_oe_n & far_pin_o);
	assign sw_port_tx_clock = pin_lvl[`P5M_PIN_TXC];
	assign sw_port_rx_clock = pin_lvl[`P5M_PIN_RXC];
	assign sw_port_collision = pin_lvl[`P5M_PIN_COL];
	assign sw_port_carrier_sense = pin_lvl[`P5M_PIN_CRS];
	modport dev (
		input sw_port_tx_enable, sw_port_tx_error, sw_port_tx_data,
		input sw_port_tx_clock, sw_port_rx_clock, sw_port_collision, sw_port_carrier_sense,
		output sw_port_rx_valid, port_rx_error, sw_port_rx_data, dev_pin_o, dev_pin_oe_n
	);
	modport far (
		output sw_port_tx_enable, sw_port_tx_error, sw_port_tx_data,
		input sw_port_tx_clock, sw_port_rx_clock, sw_port_collision, sw_port_carrier_sense,
		input sw_port_rx_valid, port_rx_error, sw_port_rx_data,
		output far_pin_o, far_pin_oe_n
	);
endinterface
`default_nettype wire

//--- design/p5m_afifo.sv
// Dual-clock buffer with gray-coded pointers between system and link
`timescale 1ns/1ps
`default_nettype none
module p5m_afifo #(
	parameter int W = 7,
	parameter int AW = 1
)
(
	// Filling side
	input wire logic wr_clk,
	input wire logic wr_rst,
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [W-1:0] wr_data,
	// Draining side
	input wire logic rd_clk,
	input wire logic rd_rst,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic [W-1:0] rd_data
);
	localparam int N = 1 << AW;
	localparam logic [AW:0] FULL_X = ~({(AW+1){1'b1}} >> 2);
	logic [W-1:0] mem_q [N];
	logic [AW:0] wbin_q, wgray_q, rbin_q, rgray_q;
	logic [AW:0] wg_s1_q, wg_s2_q, rg_s1_q, rg_s2_q;
	logic [AW:0] wbin_d, rbin_d;
	logic do_wr, do_rd;

	// Full when the write pointer is a whole lap ahead
	assign wr_ready = ((wgray_q ^ rg_s2_q) != FULL_X);
	assign rd_valid = (rgray_q != wg_s2_q);
	assign do_wr = wr_valid && wr_ready;
	assign do_rd = rd_valid && rd_ready;
	assign wbin_d = wbin_q + 1'b1;
	assign rbin_d = rbin_q + 1'b1;
	assign rd_data = mem_q[rbin_q[AW-1:0]];

	// Write pointer, storage and read pointer sync
	always_ff @(posedge wr_clk or posedge wr_rst)
	begin
		if (wr_rst)
		begin
			wbin_q <= '0;
			wgray_q <= '0;
			rg_s1_q <= '0;
			rg_s2_q <= '0;
			for (int i = 0; i < N; i++)
				mem_q[i] <= '0;
		end
		else
		begin
			rg_s1_q <= rgray_q;
			rg_s2_q <= rg_s1_q;
			if (do_wr)
			begin
				mem_q[wbin_q[AW-1:0]] <= wr_data;
				wbin_q <= wbin_d;
				wgray_q <= wbin_d ^ (wbin_d >> 1);
			end
		end
	end

	// Read pointer and write pointer sync
	always_ff @(posedge rd_clk or posedge rd_rst)
	begin
		if (rd_rst)
		begin
			rbin_q <= '0;
			rgray_q <= '0;
			wg_s1_q <= '0;
			wg_s2_q <= '0;
		end
		else
		begin
			wg_s1_q <= wgray_q;
			wg_s2_q <= wg_s1_q;
			if (do_rd)
			begin
				rbin_q <= rbin_d;
				rgray_q <= rbin_d ^ (rbin_d >> 1);
			end
		end
	end
endmodule
`default_nettype wire

//--- design/p5m_dev.sv
// Device end of the port-five media-independent link
`include "p5m_map.svh"
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RL1 - Fifth-PHY port acts only as PHY side
// RL2 - Nibble port: takes transmit, drives receive, clocks, status
// RL3 - Reduced port: two-bit data, reference clock in; in PHY role the device drives it out on RXC
// RL4 - PHY mode: takes transmit group, drives the rest
// RL5 - MAC mode: receive pins feed partner, clocks in
// RL6 - Nibble clock 25 MHz or 2.5 MHz
// RL7 - Four unencoded bits per clock, quarter rate
// RL8 - Valid and error marks each direction
// RL9 - Half duplex: collision while frame in flight
// RL10 - Switch side: no receive error, MAC ignores transmit error
// RL11 - External MAC keeps receive-error input low
// RL12 - External PHY keeps transmit-error input low
// RL13 - 96 bit-time gap between frames
// RL14 - Reduced port: one shared 50 MHz clock
// RL15 - Mode straps caught after reset, then held
// RL16 - Link outputs change on interface clock
module p5m_dev #(
	parameter bit FIFTH_PHY = 1'b0,
	parameter bit REDUCED = 1'b0,
	parameter int BUF_AW = 1
)
(
	// System clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Interface clock of the link
	input wire logic link_clk,
	// Straps
	input wire logic mac_mode_strap,
	input wire logic half_duplex_strap,
	// Egress stream, leaves on the receive pins
	input wire logic eg_valid,
	output logic eg_ready,
	input wire logic [3:0] eg_data,
	input wire logic eg_error,
	input wire logic eg_last,
	// Ingress stream, taken from the transmit pins
	output logic ig_valid,
	input wire logic ig_ready,
	output logic [3:0] ig_data,
	output logic ig_error,
	output logic ig_first,
	// Status in the system domain
	output logic mac_mode,
	output logic line_collision,
	output logic line_carrier,
	// Link pins
	p5m_if.dev link
);
	localparam int DW = REDUCED ? `P5M_DIB_W : `P5M_NIB_W;
	localparam int GAP_CYC = `P5M_IPG_BITS / DW;
	localparam logic [`P5M_GAP_W-1:0] GAP_LOAD = `P5M_GAP_W'(GAP_CYC - 1);
	localparam int WW = $bits(p5m_pkg::p5m_word_t);

	logic lrst_s1_q, lrst_q;
	logic [1:0] mstrap_q, hstrap_q, settle_q;
	logic run_q, half_q, phy_drive, err_ok;
	p5m_pkg::p5m_role_t role_q;
	p5m_pkg::p5m_eg_state_t eg_state_q;
	logic [`P5M_GAP_W-1:0] gap_q;
	p5m_pkg::p5m_word_t eg_wr, eg_rd, push_w_q, ig_rd;
	logic eg_rd_valid, drive, eg_pop, dib_hi_q;
	logic rxv_q, rxe_q, col_q, crs_q;
	logic [3:0] rxd_q, txd_q;
	logic ten_q, ter_q, ig_hi_q, fpend_q, push_q;
	logic [1:0] ig_low_q;
	logic [`P5M_PINS-1:0] pin_o, pin_oe_n;
	logic [2:0] st_s1_q, st_s2_q;

	// ----------------------------------------
	// Link-domain reset
	// ----------------------------------------
	// Released on the link clock so no link flop sees a ragged edge
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			lrst_s1_q <= 1'b1;
			lrst_q <= 1'b1;
		end
		else
		begin
			lrst_s1_q <= 1'b0;
			lrst_q <= lrst_s1_q;
		end
	end

	// Strap synchronisers, no reset needed
	always_ff @(posedge link_clk)
	begin
		mstrap_q <= {mstrap_q[0], mac_mode_strap};
		hstrap_q <= {hstrap_q[0], half_duplex_strap};
	end

	// Catch the straps once the synchronisers have filled, then hold
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			settle_q <= 2'h0;
			run_q <= 1'b0;
			half_q <= 1'b0;
			role_q <= p5m_pkg::P5M_ROLE_PHY;
		end
		else
		begin
			settle_q <= {settle_q[0], 1'b1};
			if (settle_q[1] && !run_q)
			begin
				run_q <= 1'b1; // RL15
				half_q <= hstrap_q[1];
				// The fifth-PHY port never takes the MAC role
				role_q <= (mstrap_q[1] && !FIFTH_PHY) ? p5m_pkg::P5M_ROLE_MAC :
					p5m_pkg::P5M_ROLE_PHY; // RL1
			end
		end
	end

	// ----------------------------------------
	// Egress: buffer, sender and receive pins
	// ----------------------------------------
	assign eg_wr = '{first: 1'b0, last: eg_last, err: eg_error, data: eg_data};

	p5m_afifo #(.W(WW), .AW(BUF_AW)) u_eg_buf (
		.wr_clk(ref_clk),
		.wr_rst(rst),
		.wr_valid(eg_valid),
		.wr_ready(eg_ready),
		.wr_data(eg_wr),
		.rd_clk(link_clk),
		.rd_rst(lrst_q),
		.rd_valid(eg_rd_valid),
		.rd_ready(eg_pop),
		.rd_data(eg_rd)
	);

	// A reduced word goes out as two dibits, low pair first
	always_comb
	begin
		drive = run_q && eg_rd_valid && (eg_state_q != p5m_pkg::P5M_EG_GAP);
		eg_pop = drive && (!REDUCED || dib_hi_q);
	end

	// Frame sender; an empty buffer mid-frame ends the frame
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			eg_state_q <= p5m_pkg::P5M_EG_IDLE;
			gap_q <= '0;
			dib_hi_q <= 1'b0;
		end
		else
		begin
			unique case (eg_state_q)
				p5m_pkg::P5M_EG_IDLE, p5m_pkg::P5M_EG_SEND:
				begin
					if (drive)
					begin
						dib_hi_q <= REDUCED && !dib_hi_q;
						if (eg_pop && eg_rd.last)
						begin
							eg_state_q <= p5m_pkg::P5M_EG_GAP;
							gap_q <= GAP_LOAD; // RL13
						end
						else
							eg_state_q <= p5m_pkg::P5M_EG_SEND;
					end
					else if (eg_state_q == p5m_pkg::P5M_EG_SEND)
					begin
						eg_state_q <= p5m_pkg::P5M_EG_GAP;
						gap_q <= GAP_LOAD; // RL13
					end
				end
				p5m_pkg::P5M_EG_GAP:
				begin
					// Valid stays low for at least GAP_CYC clocks
					if (gap_q == '0)
						eg_state_q <= p5m_pkg::P5M_EG_IDLE;
					else
						gap_q <= gap_q - 1'b1; // RL13
				end
			endcase
		end
	end

	// Receive pins; only the fifth-PHY port carries the error mark
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			rxv_q <= 1'b0;
			rxd_q <= 4'h0;
			rxe_q <= 1'b0;
		end
		else
		begin
			rxv_q <= drive; // RL8 RL16
			if (!drive)
				rxd_q <= 4'h0;
			else if (REDUCED)
				rxd_q <= {2'h0, dib_hi_q ? eg_rd.data[3:2] : eg_rd.data[1:0]}; // RL3
			else
				rxd_q <= eg_rd.data; // RL7
			rxe_q <= drive && FIFTH_PHY && eg_rd.err; // RL10 RL11 RL12
		end
	end
	assign link.sw_port_rx_valid = rxv_q; // RL2 RL4 RL5
	assign link.sw_port_rx_data = rxd_q;
	assign link.port_rx_error = rxe_q;

	// ----------------------------------------
	// Ingress: transmit pins into the buffer
	// ----------------------------------------
	// Error mark kept on the nibble fifth-PHY port and switch PHY mode
	assign err_ok = FIFTH_PHY ? !REDUCED : (role_q == p5m_pkg::P5M_ROLE_PHY); // RL10 RL3

	// Pins are synchronous to link_clk, so one register suffices
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			ten_q <= 1'b0;
			ter_q <= 1'b0;
			txd_q <= 4'h0;
		end
		else
		begin
			ten_q <= link.sw_port_tx_enable; // RL2 RL4 RL5
			ter_q <= link.sw_port_tx_error;
			txd_q <= link.sw_port_tx_data;
		end
	end

	// Nibble assembly; a word lost on a full buffer cannot be held back
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			ig_hi_q <= 1'b0;
			fpend_q <= 1'b1;
			ig_low_q <= 2'h0;
			push_q <= 1'b0;
			push_w_q <= '0;
		end
		else
		begin
			push_q <= 1'b0;
			if (!ten_q)
			begin
				ig_hi_q <= 1'b0;
				fpend_q <= 1'b1;
			end
			else if (run_q)
			begin
				ig_hi_q <= REDUCED && !ig_hi_q;
				ig_low_q <= txd_q[1:0];
				if (!REDUCED || ig_hi_q)
				begin
					push_q <= 1'b1;
					fpend_q <= 1'b0;
					push_w_q.first <= fpend_q; // RL8
					push_w_q.last <= 1'b0;
					push_w_q.err <= ter_q && err_ok; // RL8 RL10
					push_w_q.data <= REDUCED ? {txd_q[1:0], ig_low_q} : txd_q; // RL3 RL7
				end
			end
		end
	end

	p5m_afifo #(.W(WW), .AW(BUF_AW)) u_ig_buf (
		.wr_clk(link_clk),
		.wr_rst(lrst_q),
		.wr_valid(push_q),
		.wr_ready(),
		.wr_data(push_w_q),
		.rd_clk(ref_clk),
		.rd_rst(rst),
		.rd_valid(ig_valid),
		.rd_ready(ig_ready),
		.rd_data(ig_rd)
	);
	assign ig_data = ig_rd.data;
	assign ig_error = ig_rd.err;
	assign ig_first = ig_rd.first;

	// ----------------------------------------
	// Collision, carrier and clock pins
	// ----------------------------------------
	// Collision only in half duplex with both directions busy
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			col_q <= 1'b0;
			crs_q <= 1'b0;
		end
		else
		begin
			col_q <= half_q && ten_q && rxv_q; // RL9
			crs_q <= ten_q || rxv_q;
		end
	end

	assign phy_drive = run_q && (role_q == p5m_pkg::P5M_ROLE_PHY);

	// PHY role forwards the interface clock; the reduced port drives only the reference, on RXC
	always_comb
	begin
		pin_o = '0;
		pin_oe_n = '1;
		pin_o[`P5M_PIN_TXC] = link_clk; // RL6 RL16
		pin_o[`P5M_PIN_RXC] = link_clk;
		pin_o[`P5M_PIN_COL] = col_q;
		pin_o[`P5M_PIN_CRS] = crs_q;
		if (phy_drive)
		begin
			pin_oe_n[`P5M_PIN_RXC] = 1'b0; // RL3
			if (!REDUCED)
			begin
				pin_oe_n[`P5M_PIN_TXC] = 1'b0; // RL2 RL4
				pin_oe_n[`P5M_PIN_COL] = 1'b0; // RL9
				pin_oe_n[`P5M_PIN_CRS] = 1'b0;
			end
		end
	end
	assign link.dev_pin_o = pin_o; // RL14
	assign link.dev_pin_oe_n = pin_oe_n; // RL5

	// ----------------------------------------
	// Status into the system domain
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst)
	begin
		if (rst)
		begin
			st_s1_q <= 3'h0;
			st_s2_q <= 3'h0;
		end
		else
		begin
			st_s1_q <= {role_q == p5m_pkg::P5M_ROLE_MAC, link.sw_port_collision,
				link.sw_port_carrier_sense};
			st_s2_q <= st_s1_q;
		end
	end
	assign mac_mode = st_s2_q[2];
	assign line_collision = st_s2_q[1];
	assign line_carrier = st_s2_q[0];
endmodule
`default_nettype wire

//--- design/p5m_far.sv
// Far end of the port-five link: external MAC or external PHY
`include "p5m_map.svh"
`timescale 1ns/1ps
`default_nettype none
module p5m_far #(
	parameter bit REDUCED = 1'b0,
	parameter bit ERR_PIN = 1'b1,
	parameter int BUF_AW = 1
)
(
	// System clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Interface clock of the link
	input wire logic link_clk,
	// Role and duplex levels
	input wire logic phy_role,
	input wire logic half_duplex,
	// Send stream, leaves on the transmit pins
	input wire logic send_valid,
	output logic send_ready,
	input wire logic [3:0] send_data,
	input wire logic send_error,
	input wire logic send_last,
	// Receive stream, taken from the receive pins
	output logic recv_valid,
	input wire logic recv_ready,
	output logic [3:0] recv_data,
	output logic recv_error,
	output logic recv_first,
	// Link pins
	p5m_if.far link
);
	localparam int WW = $bits(p5m_pkg::p5m_word_t);
	logic lrst_s1_q, lrst_q, drive, pop, hi_q, idle_q;
	logic [1:0] role_q, half_q;
	logic ten_q, ter_q, rxv_q, rxe_q, ihi_q, fpend_q, push_q;
	logic [3:0] txd_q, rxd_q;
	logic [1:0] ilow_q;
	p5m_pkg::p5m_word_t s_wr, s_rd, push_w_q, r_rd;
	logic s_valid;
	logic [`P5M_PINS-1:0] pin_oe_n;

	// Link reset release and level synchronisers
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
		begin
			lrst_s1_q <= 1'b1;
			lrst_q <= 1'b1;
			role_q <= 2'h0;
			half_q <= 2'h0;
		end
		else
		begin
			lrst_s1_q <= 1'b0;
			lrst_q <= lrst_s1_q;
			role_q <= {role_q[0], phy_role};
			half_q <= {half_q[0], half_duplex};
		end
	end

	assign s_wr = '{first: 1'b0, last: send_last, err: send_error, data: send_data};
	p5m_afifo #(.W(WW), .AW(BUF_AW)) u_send_buf (
		.wr_clk(ref_clk),
		.wr_rst(rst),
		.wr_valid(send_valid),
		.wr_ready(send_ready),
		.wr_data(s_wr),
		.rd_clk(link_clk),
		.rd_rst(lrst_q),
		.rd_valid(s_valid),
		.rd_ready(pop),
		.rd_data(s_rd)
	);

	// One idle clock after each last word keeps frames apart
	assign drive = s_valid && !idle_q;
	assign pop = drive && (!REDUCED || hi_q);

	// Transmit pins; receive pins sampled on the same clock
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			hi_q <= 1'b0;
			idle_q <= 1'b0;
			ten_q <= 1'b0;
			ter_q <= 1'b0;
			txd_q <= 4'h0;
			rxv_q <= 1'b0;
			rxe_q <= 1'b0;
			rxd_q <= 4'h0;
		end
		else
		begin
			hi_q <= drive && REDUCED && !hi_q;
			idle_q <= pop && s_rd.last;
			ten_q <= drive;
			ter_q <= drive && s_rd.err && !REDUCED;
			if (!drive)
				txd_q <= 4'h0;
			else if (REDUCED)
				txd_q <= {2'h0, hi_q ? s_rd.data[3:2] : s_rd.data[1:0]};
			else
				txd_q <= s_rd.data;
			rxv_q <= link.sw_port_rx_valid;
			// Without an error pin the input reads low
			rxe_q <= ERR_PIN && link.port_rx_error; // RL11 RL12
			rxd_q <= link.sw_port_rx_data;
		end
	end
	assign link.sw_port_tx_enable = ten_q;
	assign link.sw_port_tx_error = ter_q;
	assign link.sw_port_tx_data = txd_q;

	// Receive assembly, low dibit first on the reduced port
	always_ff @(posedge link_clk or posedge lrst_q)
	begin
		if (lrst_q)
		begin
			ihi_q <= 1'b0;
			fpend_q <= 1'b1;
			ilow_q <= 2'h0;
			push_q <= 1'b0;
			push_w_q <= '0;
		end
		else
		begin
			push_q <= 1'b0;
			if (!rxv_q)
			begin
				ihi_q <= 1'b0;
				fpend_q <= 1'b1;
			end
			else
			begin
				ihi_q <= REDUCED && !ihi_q;
				ilow_q <= rxd_q[1:0];
				if (!REDUCED || ihi_q)
				begin
					push_q <= 1'b1;
					fpend_q <= 1'b0;
					push_w_q.first <= fpend_q;
					push_w_q.last <= 1'b0;
					push_w_q.err <= rxe_q;
					push_w_q.data <= REDUCED ? {rxd_q[1:0], ilow_q} : rxd_q;
				end
			end
		end
	end

	p5m_afifo #(.W(WW), .AW(BUF_AW)) u_recv_buf (
		.wr_clk(link_clk),
		.wr_rst(lrst_q),
		.wr_valid(push_q),
		.wr_ready(),
		.wr_data(push_w_q),
		.rd_clk(ref_clk),
		.rd_rst(rst),
		.rd_valid(recv_valid),
		.rd_ready(recv_ready),
		.rd_data(r_rd)
	);
	assign recv_data = r_rd.data;
	assign recv_error = r_rd.err;
	assign recv_first = r_rd.first;

	// As a nibble PHY this end owns clocks, collision and carrier
	always_comb
	begin
		pin_oe_n = '1;
		if (role_q[1] && !lrst_q && !REDUCED)
			pin_oe_n = '0;
	end
	assign link.far_pin_o = {ten_q || rxv_q, half_q[1] && ten_q && rxv_q, link_clk, link_clk};
	assign link.far_pin_oe_n = pin_oe_n;
endmodule
`default_nettype wire

//--- bench/p5m_monitor.sv
// Link-side checker for the port-five link, watching the pins between both ends
`include "p5m_map.svh"
`timescale 1ns/1ps
`default_nettype none
module p5m_monitor
(
	// Link clock and reset
	input wire logic link_clk,
	input wire logic rst,
	// Data qualifiers
	input wire logic sw_port_tx_enable,
	input wire logic sw_port_rx_valid,
	input wire logic port_rx_error,
	// Two-way pins and their resolved levels
	input wire logic [`P5M_PINS-1:0] dev_pin_oe_n,
	input wire logic [`P5M_PINS-1:0] far_pin_oe_n,
	input wire logic sw_port_collision,
	input wire logic sw_port_carrier_sense
);
	// ----------------------------------------
	// Helper logic and sequences
	// ----------------------------------------
	logic [5:0] gap_q;
	default clocking mc @(posedge link_clk);
	endclocking
	default disable iff (rst);
	// Idle cycles since the last receive nibble; saturates so the first frame passes
	always_ff @(posedge link_clk or posedge rst)
	begin
		if (rst)
			gap_q <= 6'h3F;
		else if (sw_port_rx_valid)
			gap_q <= 6'h00;
		else if (gap_q != 6'h3F)
			gap_q <= gap_q + 6'h01;
	end
	// Both directions busy long enough to pass the internal pin register
	sequence s_both;
		(sw_port_tx_enable && sw_port_rx_valid) [*2];
	endsequence
	// Both directions quiet long enough for status pins to settle
	sequence s_quiet;
		(!sw_port_tx_enable && !sw_port_rx_valid) [*4];
	endsequence
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_rx_error_low: assert property (port_rx_error == 1'b0)
		else $error("receive error pin driven on the switch side");
	a_ipg_min_gap: assert property ($rose(sw_port_rx_valid) |-> gap_q >= 6'(`P5M_IPG_BITS / `P5M_NIB_W))
		else $error("receive frame started before the idle gap ran out");
	a_carrier_on_tx: assert property (sw_port_tx_enable |-> ##[0:3] sw_port_carrier_sense)
		else $error("carrier missing while transmit enable is high");
	a_carrier_on_rx: assert property (sw_port_rx_valid |-> ##[0:3] sw_port_carrier_sense)
		else $error("carrier missing while receive valid is high");
	a_carrier_off: assert property (s_quiet |-> !sw_port_carrier_sense)
		else $error("carrier high on a quiet link");
	a_collision_on: assert property (s_both |-> ##[0:3] sw_port_collision)
		else $error("collision missing with both directions busy");
	a_collision_off: assert property (s_quiet |-> !sw_port_collision)
		else $error("collision high on a quiet link");
	a_no_contention: assert property ((~dev_pin_oe_n & ~far_pin_oe_n) == 4'h0)
		else $error("both ends drive the same pin");
	a_phy_pins_all: assert property (!dev_pin_oe_n[`P5M_PIN_RXC] |-> dev_pin_oe_n == 4'h0)
		else $error("device in PHY role leaves a clock or status pin undriven");
	a_mac_pins_none: assert property (!far_pin_oe_n[`P5M_PIN_RXC] |-> dev_pin_oe_n == 4'hF)
		else $error("device drives a pin while the far end is PHY");
	a_role_held: assert property (!dev_pin_oe_n[`P5M_PIN_RXC] |=> !dev_pin_oe_n[`P5M_PIN_RXC])
		else $error("device dropped its role during operation");
	a_quiet_reset: assert property ($fell(rst) |-> (dev_pin_oe_n == 4'hF) [*2])
		else $error("device drove pins before its straps were caught");
endmodule
`default_nettype wire

//--- bench/port5_mii_rmii_interface_tb.sv
// Testbench joining device end and far end of the port-five link
`timescale 1ns/1ps
`default_nettype none
module port5_mii_rmii_interface_tb;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic ref_clk = 1'b0;
	logic link_clk = 1'b0;
	logic rst = 1'b1;
	logic mode_sel = 1'b0;
	logic s_valid [2] = '{1'b0, 1'b0};
	logic s_err [2] = '{1'b0, 1'b0};
	logic s_last [2] = '{1'b0, 1'b0};
	logic [3:0] s_data [2] = '{4'h0, 4'h0};
	logic first_q [2] = '{1'b1, 1'b1};
	logic eg_ready, send_ready, ig_valid, ig_error, ig_first, recv_valid, recv_error, recv_first;
	logic ig_ready = 1'b1;
	logic recv_ready = 1'b1;
	logic [3:0] ig_data, recv_data;
	logic mac_mode, line_collision, line_carrier;
	logic [2:0] cyc_q = 3'h0;
	logic [5:0] exp_ig[$], got_ig[$], exp_rc[$], got_rc[$];
	int bad_count = 0;
	int n_checks = 0;
	int col_n = 0, crs_n = 0, stall_n = 0, c0, k0, s0, n;
	p5m_if p();
	// Deeper buffers ride out the pointer sync lag at the bench clock rates
	p5m_dev #(.BUF_AW(3)) i_p5m_dev (.ref_clk(ref_clk), .rst(rst),
		.link_clk(link_clk), .mac_mode_strap(mode_sel), .half_duplex_strap(1'b1),
		.eg_valid(s_valid[0]), .eg_ready(eg_ready), .eg_data(s_data[0]), .eg_error(s_err[0]),
		.eg_last(s_last[0]), .ig_valid(ig_valid), .ig_ready(ig_ready), .ig_data(ig_data),
		.ig_error(ig_error), .ig_first(ig_first), .mac_mode(mac_mode),
		.line_collision(line_collision), .line_carrier(line_carrier), .link(p));
	p5m_far #(.BUF_AW(3)) i_p5m_far (.ref_clk(ref_clk), .rst(rst),
		.link_clk(link_clk), .phy_role(mode_sel), .half_duplex(1'b1), .send_valid(s_valid[1]),
		.send_ready(send_ready), .send_data(s_data[1]), .send_error(s_err[1]),
		.send_last(s_last[1]), .recv_valid(recv_valid), .recv_ready(recv_ready),
		.recv_data(recv_data), .recv_error(recv_error), .recv_first(recv_first), .link(p));
	p5m_monitor i_p5m_monitor (.link_clk(link_clk), .rst(rst),
		.sw_port_tx_enable(p.sw_port_tx_enable), .sw_port_rx_valid(p.sw_port_rx_valid),
		.port_rx_error(p.port_rx_error), .dev_pin_oe_n(p.dev_pin_oe_n),
		.far_pin_oe_n(p.far_pin_oe_n), .sw_port_collision(p.sw_port_collision),
		.sw_port_carrier_sense(p.sw_port_carrier_sense));
	// ----------------------------------------
	// Clocks, receivers and tasks
	// ----------------------------------------
	// System clock, 5 ns
	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end
	// Link clock, 6 ns, offset so no edge lines up with the system clock
	initial
	begin
		#1.3;
		forever #3 link_clk = ~link_clk;
	end
	// Receivers pause one cycle in eight so both buffers see back-pressure
	always @(posedge ref_clk)
	begin
		cyc_q <= cyc_q + 3'h1;
		ig_ready <= (cyc_q != 3'h0);
		recv_ready <= (cyc_q != 3'h4);
		if (ig_valid === 1'b1 && ig_ready) got_ig.push_back({ig_first, ig_error, ig_data});
		if (recv_valid === 1'b1 && recv_ready) got_rc.push_back({recv_first, recv_error, recv_data});
		if (line_collision === 1'b1) col_n++;
		if (line_carrier === 1'b1) crs_n++;
		if ((s_valid[0] && eg_ready === 1'b0) || (s_valid[1] && send_ready === 1'b0)) stall_n++;
	end
	// Compare one value and count it
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] want);
		n_checks++;
		if (seen !== want)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, want, seen);
		end
	endtask
	// One nibble on side f (0 device egress, 1 far send), held until taken
	task automatic put(input int f, input logic [3:0] d, input logic e, input logic l);
		int w;
		w = 0;
		s_valid[f] <= 1'b1;
		s_data[f] <= d;
		s_err[f] <= e;
		s_last[f] <= l;
		do
		begin
			@(posedge ref_clk);
			w++;
		end
		while ((f == 1 ? send_ready : eg_ready) !== 1'b1 && w < 500);
		// Switch-side error pins never carry egress errors; ingress errors only in PHY mode
		if (f == 1)
			exp_ig.push_back({first_q[1], e & ~mode_sel, d});
		else
			exp_rc.push_back({first_q[0], 1'b0, d});
		first_q[f] = l;
	endtask
	// A whole frame, then one edge with valid low so the next call starts cleanly
	task automatic frame(input int f, input int len, input int base, input int err_at);
		for (int i = 0; i < len; i++)
			put(f, 4'(base + i), i == err_at, i == len - 1);
		s_valid[f] <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic test_done();
		if (bad_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests: PHY mode, then MAC mode after a second reset
	// ----------------------------------------
	initial
	begin
		for (int m = 0; m < 2; m++)
		begin
			@(posedge ref_clk);
			mode_sel <= m[0];
			@(posedge ref_clk);
			rst <= 1'b1;
			repeat (12) @(posedge ref_clk);
			rst <= 1'b0;
			repeat (30) @(posedge ref_clk);
			chk("mac_mode", {7'h00, mac_mode}, {7'h00, m[0]});
			// Driven clock pins follow the link clock in either role
			repeat (2)
			begin
				@(posedge link_clk);
				#1;
				chk("clk_hi", {6'h00, p.sw_port_tx_clock, p.sw_port_rx_clock}, 8'h03);
				@(negedge link_clk);
				#1;
				chk("clk_lo", {6'h00, p.sw_port_tx_clock, p.sw_port_rx_clock}, 8'h00);
			end
			@(posedge ref_clk);
			c0 = col_n;
			k0 = crs_n;
			s0 = stall_n;
			// Long frames start together so the directions overlap and collide
			fork
				begin
					frame(0, 40, 3, 5);
					frame(0, 1, 9, 0);
					frame(0, 2, 12, 9);
				end
				begin
					frame(1, 40, 7, 2);
					frame(1, 1, 14, 9);
				end
			join
			n = 0;
			while ((got_ig.size() < exp_ig.size() || got_rc.size() < exp_rc.size()) && n < 4000)
			begin
				@(posedge ref_clk);
				n++;
			end
			repeat (40) @(posedge ref_clk);
			chk("ig_count", 8'(got_ig.size()), 8'(exp_ig.size()));
			chk("rc_count", 8'(got_rc.size()), 8'(exp_rc.size()));
			foreach (exp_ig[i]) chk("ig_word", {2'h0, got_ig[i]}, {2'h0, exp_ig[i]});
			foreach (exp_rc[i]) chk("rc_word", {2'h0, got_rc[i]}, {2'h0, exp_rc[i]});
			chk("collision", 8'(col_n > c0), 8'h01);
			chk("carrier", 8'(crs_n > k0), 8'h01);
			chk("stall", 8'(stall_n > s0), 8'h01);
			exp_ig.delete();
			got_ig.delete();
			exp_rc.delete();
			got_rc.delete();
		end
		test_done();
	end
	// Watchdog: both modes need a few microseconds
	initial
	begin
		#40000;
		bad_count++;
		test_done();
	end
endmodule
`default_nettype wire
